// ==== core/conv_ctrl.sv ====
`timescale 1ns/100ps
module conv_ctrl #(
  parameter int RES_BITS = 12,
  parameter bit HAS_DAC_REF = 1'b1
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic tmr2_ovf_i,
  input wire logic tmr3_ovf_i,
  input wire logic ext_start_i,
  input wire logic conv_done_i,
  input wire logic [RES_BITS-1:0] conv_data_i,
  output logic conv_start_o,
  output logic [3:0] channel_o,
  output logic [3:0] diff_pair_o,
  output logic [2:0] gain_o,
  output logic ref_dac_o,
  output logic shutdown_o,
  output logic irq_o
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  localparam int NUM_EVT = conv_ctrl_pkg::NUM_EVT;
  logic [6:0] ctrl_q;
  logic [7:0] chan_q;
  logic [2:0] gain_q;
  logic [11:0] win_lo_q;
  logic [11:0] win_hi_q;
  logic [7:0] res_hi_q;
  logic [7:0] res_lo_q;
  logic [NUM_EVT-1:0] sts_q;
  logic [NUM_EVT-1:0] sts_d;
  logic [NUM_EVT-1:0] int_en_q;
  logic sw_go_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic ext_meta_q;
  logic ext_sync_q;
  logic ext_prev_q;
  conv_ctrl_pkg::conv_state_t state_q;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire addr_ph = hsel_i & hready_i & (htrans_i == conv_ctrl_pkg::HTRANS_NONSEQ);
  wire rd_take = addr_ph & ~hwrite_i;
  wire wr_take = addr_ph & hwrite_i;
  wire [7:0] rd_addr = haddr_i[7:0];
  wire wr_ctrl = wr_pend_q & (wr_addr_q == conv_ctrl_pkg::OFF_CTRL);
  wire wr_chan = wr_pend_q & (wr_addr_q == conv_ctrl_pkg::OFF_CHAN);
  wire wr_gain = wr_pend_q & (wr_addr_q == conv_ctrl_pkg::OFF_GAIN);
  wire wr_wlo = wr_pend_q & (wr_addr_q == conv_ctrl_pkg::OFF_WIN_LO);
  wire wr_whi = wr_pend_q & (wr_addr_q == conv_ctrl_pkg::OFF_WIN_HI);
  wire wr_ien = wr_pend_q & (wr_addr_q == conv_ctrl_pkg::OFF_INT_EN);
  wire wr_clr = wr_pend_q & (wr_addr_q == conv_ctrl_pkg::OFF_INT_CLR);
  wire [NUM_EVT-1:0] clr_bits = wr_clr ? hwdata_i[NUM_EVT-1:0] : '0;

  // out-of-range gain codes saturate at the top setting
  wire [2:0] gain_wr = (hwdata_i[2:0] > conv_ctrl_pkg::GAIN_MAX) ?
                       conv_ctrl_pkg::GAIN_MAX : hwdata_i[2:0];
  // without a dac reference the select bit stays zero
  wire ref_dac_wr = hwdata_i[conv_ctrl_pkg::CTRL_REF_DAC] & HAS_DAC_REF;

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  wire enabled = ctrl_q[conv_ctrl_pkg::CTRL_ENABLE];
  wire [1:0] trig_sel = ctrl_q[conv_ctrl_pkg::CTRL_TRIG_LSB +: 2];
  wire left_just = ctrl_q[conv_ctrl_pkg::CTRL_LEFT];
  wire win_outside = ctrl_q[conv_ctrl_pkg::CTRL_OUTSIDE];
  wire cont_mode = ctrl_q[conv_ctrl_pkg::CTRL_CONT];

  // ----------------------------------------------------------------
  // trigger selection and conversion sequencing
  // ----------------------------------------------------------------
  wire ext_edge = ext_sync_q & ~ext_prev_q;
  logic trig_fire;
  always_comb
  begin
    case (trig_sel)
      conv_ctrl_pkg::TRIG_SW: trig_fire = sw_go_q;
      conv_ctrl_pkg::TRIG_TMR2: trig_fire = tmr2_ovf_i;
      conv_ctrl_pkg::TRIG_TMR3: trig_fire = tmr3_ovf_i;
      default: trig_fire = ext_edge;
    endcase
  end
  // triggers count only from idle; a busy converter drops them
  wire start_acc = (state_q == conv_ctrl_pkg::ST_IDLE) & enabled & trig_fire;
  wire done_acc = (state_q == conv_ctrl_pkg::ST_CONV) & conv_done_i;
  // background mode chains the next conversion onto each result
  wire restart = done_acc & cont_mode & enabled;

  // ----------------------------------------------------------------
  // result shaping and window compare
  // ----------------------------------------------------------------
  wire [15:0] res_right = 16'(conv_data_i);
  wire [15:0] res_left = 16'(conv_data_i) << (16 - RES_BITS);
  wire [15:0] res_val = left_just ? res_left : res_right;
  wire [11:0] res_cmp = 12'(conv_data_i);
  wire in_window = (res_cmp >= win_lo_q) & (res_cmp <= win_hi_q);
  wire win_hit = win_outside ? ~in_window : in_window;
  wire [NUM_EVT-1:0] evt = {done_acc & win_hit, done_acc};

  // set wins over a clear in the same cycle
  always_comb
  begin
    sts_d = (sts_q & ~clr_bits) | evt;
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  logic [31:0] rd_val;
  always_comb
  begin
    case (rd_addr)
      conv_ctrl_pkg::OFF_CTRL: rd_val = {25'h0, ctrl_q};
      conv_ctrl_pkg::OFF_CHAN: rd_val = {24'h0, chan_q};
      conv_ctrl_pkg::OFF_GAIN: rd_val = {29'h0, gain_q};
      conv_ctrl_pkg::OFF_RES_HI: rd_val = {24'h0, res_hi_q};
      conv_ctrl_pkg::OFF_RES_LO: rd_val = {24'h0, res_lo_q};
      conv_ctrl_pkg::OFF_WIN_LO: rd_val = {20'h0, win_lo_q};
      conv_ctrl_pkg::OFF_WIN_HI: rd_val = {20'h0, win_hi_q};
      conv_ctrl_pkg::OFF_STATUS: rd_val = {29'h0, state_q, sts_q};
      conv_ctrl_pkg::OFF_INT_EN: rd_val = {30'h0, int_en_q};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata_o <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
    else if (ce_i)
    begin
      wr_pend_q <= wr_take;
      wr_addr_q <= rd_addr;
      hrdata_o <= rd_take ? rd_val : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_q <= conv_ctrl_pkg::CTRL_RST;
      chan_q <= conv_ctrl_pkg::CHAN_RST;
      gain_q <= conv_ctrl_pkg::GAIN_RST;
      win_lo_q <= conv_ctrl_pkg::WIN_LO_RST;
      win_hi_q <= conv_ctrl_pkg::WIN_HI_RST;
      int_en_q <= '0;
      sw_go_q <= 1'b0;
    end
    else if (ce_i)
    begin
      if (wr_ctrl)
        ctrl_q <= {ref_dac_wr, hwdata_i[5:0]};
      if (wr_chan)
        chan_q <= hwdata_i[7:0];
      if (wr_gain)
        gain_q <= gain_wr;
      if (wr_wlo)
        win_lo_q <= hwdata_i[11:0];
      if (wr_whi)
        win_hi_q <= hwdata_i[11:0];
      if (wr_ien)
        int_en_q <= hwdata_i[NUM_EVT-1:0];
      // self-clearing start strobe
      sw_go_q <= wr_ctrl & hwdata_i[conv_ctrl_pkg::CTRL_SW_START];
    end
  end

  // ----------------------------------------------------------------
  // converter sequencing, result and status
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      ext_meta_q <= 1'b0;
      ext_sync_q <= 1'b0;
      ext_prev_q <= 1'b0;
      state_q <= conv_ctrl_pkg::ST_IDLE;
      conv_start_o <= 1'b0;
      res_hi_q <= 8'h00;
      res_lo_q <= 8'h00;
      sts_q <= '0;
      irq_o <= 1'b0;
    end
    else if (ce_i)
    begin
      ext_meta_q <= ext_start_i;
      ext_sync_q <= ext_meta_q;
      ext_prev_q <= ext_sync_q;
      conv_start_o <= start_acc | restart;
      case (state_q)
        conv_ctrl_pkg::ST_IDLE:
          if (start_acc)
            state_q <= conv_ctrl_pkg::ST_CONV;
        conv_ctrl_pkg::ST_CONV:
          if (done_acc & ~restart)
            state_q <= conv_ctrl_pkg::ST_IDLE;
        default: state_q <= conv_ctrl_pkg::ST_IDLE;
      endcase
      if (done_acc)
      begin
        res_hi_q <= res_val[15:8];
        res_lo_q <= res_val[7:0];
      end
      sts_q <= sts_d;
      irq_o <= |(sts_d & int_en_q);
    end
  end

  // ----------------------------------------------------------------
  // analog selects
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      channel_o <= 4'h0;
      diff_pair_o <= 4'h0;
      gain_o <= conv_ctrl_pkg::GAIN_RST;
      ref_dac_o <= 1'b0;
      shutdown_o <= 1'b1;
    end
    else if (ce_i)
    begin
      // codes above the sensor index fall back to the sensor
      channel_o <= (chan_q[3:0] > conv_ctrl_pkg::TEMP_CHAN) ?
                   conv_ctrl_pkg::TEMP_CHAN : chan_q[3:0];
      diff_pair_o <= chan_q[conv_ctrl_pkg::CHAN_DIFF_LSB +: 4];
      gain_o <= gain_q;
      ref_dac_o <= ctrl_q[conv_ctrl_pkg::CTRL_REF_DAC];
      shutdown_o <= ~enabled;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence seq_done;
    ce_i && done_acc;
  endsequence
  sequence seq_next_start;
    ##1 conv_start_o;
  endsequence

  AST_TRIG_START: assert property (ce_i && start_acc |=> conv_start_o)
    else $error("accepted trigger gave no start pulse");
  AST_DONE_FLAG: assert property (seq_done |=> sts_q[conv_ctrl_pkg::STS_DONE])
    else $error("completion flag not set");
  AST_DONE_IRQ: assert property (seq_done ##0 int_en_q[0] |=> irq_o)
    else $error("enabled completion gave no interrupt");
  AST_RESULT_RIGHT: assert property (seq_done ##0 !left_just
    |=> {res_hi_q, res_lo_q} == 16'($past(conv_data_i)))
    else $error("right-justified result not latched");
  AST_RESULT_LEFT: assert property (seq_done ##0 left_just
    |=> {res_hi_q, res_lo_q} == (16'($past(conv_data_i)) << (16 - RES_BITS)))
    else $error("left-justified result wrong");
  AST_WIN_HIT: assert property (seq_done ##0 win_hit
    |=> sts_q[conv_ctrl_pkg::STS_WIN])
    else $error("window hit not flagged");
  AST_WIN_MISS: assert property (seq_done ##0 !win_hit ##0 !sts_q[1]
    |=> !sts_q[conv_ctrl_pkg::STS_WIN])
    else $error("window miss raised a flag");
  AST_BG_RESTART: assert property (seq_done ##0 cont_mode ##0 enabled
    |-> seq_next_start)
    else $error("background mode did not restart");
  AST_SHUTDOWN_QUIET: assert property (shutdown_o && !enabled |=> !conv_start_o)
    else $error("start issued while shut down");
  AST_BUSY_IGNORE: assert property (ce_i && state_q == conv_ctrl_pkg::ST_CONV && !done_acc
    |=> !conv_start_o)
    else $error("start issued during conversion");
  AST_STICKY: assert property (ce_i && sts_q[0] && !clr_bits[0]
    |=> sts_q[conv_ctrl_pkg::STS_DONE])
    else $error("completion flag dropped without clear");
endmodule

// ==== core/conv_ctrl_pkg.sv ====
package conv_ctrl_pkg;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CHAN = 8'h04;
  localparam logic [7:0] OFF_GAIN = 8'h08;
  localparam logic [7:0] OFF_RES_HI = 8'h0C;
  localparam logic [7:0] OFF_RES_LO = 8'h10;
  localparam logic [7:0] OFF_WIN_LO = 8'h14;
  localparam logic [7:0] OFF_WIN_HI = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1C;
  localparam logic [7:0] OFF_INT_EN = 8'h20;
  localparam logic [7:0] OFF_INT_CLR = 8'h24;
  // ----------------------------------------------------------------
  // control and channel register fields
  // ----------------------------------------------------------------
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_TRIG_LSB = 1;
  localparam int CTRL_LEFT = 3;
  localparam int CTRL_OUTSIDE = 4;
  localparam int CTRL_CONT = 5;
  localparam int CTRL_REF_DAC = 6;
  localparam int CTRL_SW_START = 7;
  localparam int CHAN_DIFF_LSB = 4;
  // ----------------------------------------------------------------
  // status / interrupt bits
  // ----------------------------------------------------------------
  localparam int STS_DONE = 0;
  localparam int STS_WIN = 1;
  localparam int STS_BUSY = 2;
  localparam int NUM_EVT = 2;
  // ----------------------------------------------------------------
  // reset values, limits and bus codes
  // ----------------------------------------------------------------
  localparam logic [6:0] CTRL_RST = 7'h00;
  localparam logic [7:0] CHAN_RST = 8'h00;
  localparam logic [2:0] GAIN_RST = 3'h1;
  localparam logic [11:0] WIN_LO_RST = 12'h000;
  localparam logic [11:0] WIN_HI_RST = 12'hFFF;
  localparam logic [3:0] TEMP_CHAN = 4'h8;
  localparam logic [2:0] GAIN_MAX = 3'h5;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

  typedef enum logic [1:0] {TRIG_SW = 2'b00, TRIG_TMR2 = 2'b01, TRIG_TMR3 = 2'b10,
                            TRIG_EXT = 2'b11} trig_t;
  typedef enum logic {ST_IDLE = 1'b0, ST_CONV = 1'b1} conv_state_t;
endpackage

// ==== verif/conv_model.sv ====
`timescale 1ns/100ps
// ----------------------------------------------------------------
// converter stand-in: one answer per start, after lat_i cycles
// ----------------------------------------------------------------
module conv_model #(
  parameter int RES_BITS = 12
) (
  input wire logic clk_i,
  input wire logic start_i,
  input wire logic [RES_BITS-1:0] sample_i,
  input wire logic [15:0] lat_i,
  output logic done_o,
  output logic [RES_BITS-1:0] data_o
);
  int cnt = 0;
  logic [RES_BITS-1:0] last_q = '0;
  initial done_o = 1'b0;
  initial data_o = '0;
  // a slow answer keeps back-to-back restarts at or above 200 cycles
  always @(posedge clk_i)
  begin
    done_o <= 1'b0;
    data_o <= ~last_q;
    if (start_i === 1'b1)
      cnt <= int'(lat_i);
    else if (cnt == 1)
    begin
      done_o <= 1'b1;
      data_o <= sample_i;
      last_q <= sample_i;
      cnt <= 0;
    end
    else if (cnt > 1)
      cnt <= cnt - 1;
  end
endmodule

// ==== verif/tb.sv ====
`timescale 1ns/100ps
module tb;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic tmr2 = 1'b0;
  logic tmr3 = 1'b0;
  logic ext_start = 1'b0;
  logic [11:0] sample = 12'h000;
  logic ce = 1'b1;
  logic hsel = 1'b0;
  logic hresp;
  logic [31:0] hrdata;
  logic hreadyout;
  logic conv_done;
  logic [11:0] conv_data;
  logic conv_start;
  logic [3:0] channel;
  logic [3:0] diff_pair;
  logic [2:0] gain;
  logic ref_dac;
  logic shutdown;
  logic irq;
  int mismatches = 0;
  int checks_done = 0;
  int starts = 0;
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) if (conv_start === 1'b1) starts <= starts + 1;
  conv_ctrl #(.RES_BITS(12), .HAS_DAC_REF(1'b1)) dut_u (.core_clk_i(core_clk),
    .rst_n_i(rst_n), .ce_i(ce), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hreadyout),
    .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp), .tmr2_ovf_i(tmr2),
    .tmr3_ovf_i(tmr3), .ext_start_i(ext_start), .conv_done_i(conv_done),
    .conv_data_i(conv_data), .conv_start_o(conv_start), .channel_o(channel),
    .diff_pair_o(diff_pair), .gain_o(gain), .ref_dac_o(ref_dac), .shutdown_o(shutdown),
    .irq_o(irq));
  conv_model #(.RES_BITS(12)) model_u (.clk_i(core_clk), .start_i(conv_start),
    .sample_i(sample), .lat_i(16'h00C8), .done_o(conv_done), .data_o(conv_data));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task final_report;
    if (mismatches == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task hang;
    mismatches++;
    final_report;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // registered outputs read at the falling edge hold what the next rise samples
  task rdy(output logic [31:0] rd);
    int n;
    n = 0;
    do
    begin
      @(negedge core_clk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) hang;
    rd = hrdata;
    @(posedge core_clk);
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    logic [31:0] tmp;
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= conv_ctrl_pkg::HTRANS_NONSEQ;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    rdy(tmp);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    rdy(rd);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0000_0000, r);
    chk(r, e);
  endtask
  task look;
    repeat (2) @(negedge core_clk);
  endtask
  task clr;
    wr(conv_ctrl_pkg::OFF_INT_CLR, 32'h0000_0003);
  endtask
  task fire(input logic [1:0] t, input logic [7:0] c);
    if (t == 2'h0)
      wr(conv_ctrl_pkg::OFF_CTRL, {24'h00_0000, c | 8'h80});
    else
    begin
      @(posedge core_clk);
      tmr2 <= (t == 2'h1);
      tmr3 <= (t == 2'h2);
      ext_start <= (t == 2'h3);
      @(posedge core_clk);
      tmr2 <= 1'b0;
      tmr3 <= 1'b0;
      repeat (4) @(posedge core_clk);
      ext_start <= 1'b0;
    end
  endtask
  task wait_bit(input int b);
    logic [31:0] r;
    int n;
    n = 0;
    do
    begin
      bus(1'b0, conv_ctrl_pkg::OFF_STATUS, 32'h0000_0000, r);
      n++;
    end
    while (r[b] !== 1'b1 && n < 400);
    if (r[b] !== 1'b1) hang;
  endtask
  task conv(input logic [1:0] t, input logic [11:0] v, input logic [7:0] m);
    sample <= v;
    wr(conv_ctrl_pkg::OFF_CTRL, {24'h00_0000, m | {5'h00, t, 1'b1}});
    fire(t, m | {5'h00, t, 1'b1});
    wait_bit(0);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_reset;
    chk(32'(shutdown), 32'h0000_0001);
    chk(32'(irq), 32'h0000_0000);
    chk(32'(hresp), 32'h0000_0000);
    rdc(conv_ctrl_pkg::OFF_GAIN, 32'h0000_0001);
    rdc(conv_ctrl_pkg::OFF_WIN_HI, 32'h0000_0FFF);
    rdc(conv_ctrl_pkg::OFF_STATUS, 32'h0000_0000);
    rdc(8'h3C, 32'h0000_0000);
  endtask
  task t_cfg;
    wr(conv_ctrl_pkg::OFF_CHAN, 32'h0000_00AF);
    look;
    chk(32'(channel), 32'(conv_ctrl_pkg::TEMP_CHAN));
    chk(32'(diff_pair), 32'h0000_000A);
    for (int g = 0; g < 8; g++)
    begin
      wr(conv_ctrl_pkg::OFF_GAIN, 32'(g));
      look;
      chk(32'(gain), (g > 5) ? 32'h0000_0005 : 32'(g));
    end
    wr(conv_ctrl_pkg::OFF_CTRL, 32'h0000_0041);
    look;
    chk(32'(ref_dac), 32'h0000_0001);
    chk(32'(shutdown), 32'h0000_0000);
    wr(conv_ctrl_pkg::OFF_CTRL, 32'h0000_0000);
    look;
    chk(32'(shutdown), 32'h0000_0001);
  endtask
  // a timer pulse that lands while the clock enable is low must be lost
  task t_freeze;
    int s;
    s = starts;
    wr(conv_ctrl_pkg::OFF_CTRL, 32'h0000_0003);
    @(posedge core_clk);
    ce <= 1'b0;
    tmr2 <= 1'b1;
    @(posedge core_clk);
    tmr2 <= 1'b0;
    repeat (3) @(posedge core_clk);
    ce <= 1'b1;
    look;
    chk(32'(starts - s), 32'h0000_0000);
    wr(conv_ctrl_pkg::OFF_CTRL, 32'h0000_0000);
  endtask
  task t_trig;
    logic [11:0] v;
    int s;
    wr(conv_ctrl_pkg::OFF_INT_EN, 32'h0000_0001);
    for (int t = 0; t < 4; t++)
    begin
      v = 12'hA50 + 12'(t);
      s = starts;
      conv(2'(t), v, 8'h00);
      look;
      chk(32'(starts - s), 32'h0000_0001);
      chk(32'(irq), 32'h0000_0001);
      rdc(conv_ctrl_pkg::OFF_RES_HI, {28'h000_0000, v[11:8]});
      rdc(conv_ctrl_pkg::OFF_RES_LO, {24'h00_0000, v[7:0]});
      rdc(conv_ctrl_pkg::OFF_STATUS, 32'h0000_0003);
      clr;
      look;
      chk(32'(irq), 32'h0000_0000);
      rdc(conv_ctrl_pkg::OFF_STATUS, 32'h0000_0000);
    end
  endtask
  task t_left;
    wr(conv_ctrl_pkg::OFF_INT_EN, 32'h0000_0000);
    conv(2'h0, 12'h9B7, 8'h08);
    look;
    chk(32'(irq), 32'h0000_0000);
    rdc(conv_ctrl_pkg::OFF_RES_HI, 32'h0000_009B);
    rdc(conv_ctrl_pkg::OFF_RES_LO, 32'h0000_0070);
    clr;
  endtask
  task t_busy;
    int s;
    s = starts;
    sample <= 12'h123;
    wr(conv_ctrl_pkg::OFF_CTRL, 32'h0000_0003);
    fire(2'h1, 8'h03);
    repeat (3) @(posedge core_clk);
    fire(2'h1, 8'h03);
    wait_bit(0);
    look;
    chk(32'(starts - s), 32'h0000_0001);
    clr;
  endtask
  task t_window;
    logic [11:0] wv [5];
    logic [4:0] outs;
    logic [4:0] hit;
    wv = '{12'h150, 12'h300, 12'h200, 12'h0FF, 12'h150};
    outs = 5'b11000;
    hit = 5'b01101;
    wr(conv_ctrl_pkg::OFF_WIN_LO, 32'h0000_0100);
    wr(conv_ctrl_pkg::OFF_WIN_HI, 32'h0000_0200);
    wr(conv_ctrl_pkg::OFF_INT_EN, 32'h0000_0002);
    for (int i = 0; i < 5; i++)
    begin
      conv(2'h0, wv[i], outs[i] ? 8'h10 : 8'h00);
      look;
      rdc(conv_ctrl_pkg::OFF_STATUS, {30'h0000_0000, hit[i], 1'b1});
      chk(32'(irq), 32'(hit[i]));
      clr;
    end
  endtask
  task t_cont;
    int s;
    s = starts;
    sample <= 12'h300;
    wr(conv_ctrl_pkg::OFF_CTRL, 32'h0000_0021);
    fire(2'h0, 8'h21);
    repeat (650) @(posedge core_clk);
    look;
    chk(32'(irq), 32'h0000_0000);
    chk(32'(starts - s > 2), 32'h0000_0001);
    sample <= 12'h180;
    wait_bit(1);
    look;
    chk(32'(irq), 32'h0000_0001);
    wr(conv_ctrl_pkg::OFF_CTRL, 32'h0000_0000);
    repeat (230) @(posedge core_clk);
    clr;
  endtask
  initial
  begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset;
    t_cfg;
    t_freeze;
    t_trig;
    t_left;
    t_busy;
    t_window;
    t_cont;
    final_report;
  end
endmodule
